/* File: hdl/i2cp_pkg.sv */
package i2cp_pkg;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int STD_BIT_NS    = 10000;
  localparam int PHASES_PER_BIT = 4;
  localparam int BRG_W         = 10;
  // Phase length in cycles minus one, from the Standard-mode bit time
  localparam logic [BRG_W-1:0] BRG_DEF =
    BRG_W'(STD_BIT_NS / CLK_PERIOD_NS / PHASES_PER_BIT - 1);

  // Register byte addresses
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CON  = 8'h00;
  localparam logic [AW-1:0] A_OWN  = 8'h04;
  localparam logic [AW-1:0] A_TX   = 8'h08;
  localparam logic [AW-1:0] A_RX   = 8'h0C;
  localparam logic [AW-1:0] A_STAT = 8'h10;
  localparam logic [AW-1:0] A_IFLG = 8'h14;
  localparam logic [AW-1:0] A_ICLR = 8'h18;
  localparam logic [AW-1:0] A_IEN  = 8'h1C;
  localparam logic [AW-1:0] A_BRG  = 8'h20;

  // Control register fields
  localparam int B_EN    = 15;
  localparam int B_SIDL  = 13;
  localparam int B_REL   = 12;
  localparam int B_IPMI  = 11;
  localparam int B_A10   = 10;
  localparam int B_SLW   = 9;
  localparam int B_SMB   = 8;
  localparam int B_GENERAL_CALL_ENABLE  = 7;
  localparam int B_STRETCH_ENABLE = 6;
  localparam int B_ACK_VALUE = 5;
  localparam int B_ACK_SEND_REQUEST = 4;
  localparam int B_RECEIVE_REQUEST  = 3;
  localparam int B_PEN   = 2;
  localparam int B_RESTART_REQUEST  = 1;
  localparam int B_SEN   = 0;
  localparam logic [15:0] CON_RST   = 16'h1000;
  localparam logic [15:0] CON_WMASK = 16'hBFFF;
  localparam logic [15:0] CON_REQS  = 16'h001F;

  // Interrupt events
  localparam int EV_N   = 3;
  localparam int EV_MST = 0;
  localparam int EV_SLV = 1;
  localparam int EV_BCL = 2;

  // Bus framing
  localparam logic [3:0] BITS_BYTE = 4'h8;
  localparam logic [3:0] BITS_ACK  = 4'h9;
  localparam logic [4:0] HDR10     = 5'h1E;
  localparam logic [7:0] GCALL     = 8'h00;

  typedef enum logic [5:0] {
    M_IDLE  = 6'h01,
    M_START = 6'h02,
    M_STOP  = 6'h04,
    M_TX    = 6'h08,
    M_RX    = 6'h10,
    M_ACK   = 6'h20
  } i2cp_mst_t;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h01,
    S_ADDR  = 5'h02,
    S_ADDR2 = 5'h04,
    S_RX    = 5'h08,
    S_TX    = 5'h10
  } i2cp_slv_t;

endpackage

/* File: hdl/i2cp_port.sv */
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
// Contract
// [RULE1] Control and status reach software through registers sixteen bits wide.
// [RULE2] Each port uses one serial clock line and one bidirectional serial data line.
// [RULE3] As a slave the port recognises its own address in 7-bit or 10-bit form.
// [RULE4] As a master the port can address targets with 7-bit or 10-bit addresses.
// [RULE5] The port carries out master and slave functions of Standard and Fast mode.
// [RULE6] A slave may hold the clock low and resumes only when software releases it.
// [RULE7] In multi-master use a data line differing from the driven level loses arbitration.
// [RULE8] The address width select bit makes the own address 10-bit when set, 7-bit when clear.
// [RULE9] Ack, receive, stop, restart and start requests reset to 0 and clear when done.
// [RULE10] Clock release resets to 1, 0 holds the clock, and it clears as slave sending starts.
// [RULE11] The enable bit hands both pins to the port; when clear the port is inactive.
// [RULE12] With stretch enable software writes 0 or 1 to release, without it only 1.
module i2cp_port #(
  parameter logic [i2cp_pkg::BRG_W-1:0] BRG_INIT = i2cp_pkg::BRG_DEF
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    nrst,
  // Wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [i2cp_pkg::AW-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // Serial clock pin, open drain
  input  wire logic                    scl_i,
  output logic                         scl_o,
  output logic                         scl_oe_n,
  // Serial data pin, open drain
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_n,
  // Pin ownership and interrupt
  output logic                         pins_owned,
  output logic                         irq
);
  import i2cp_pkg::*;

  typedef struct packed {
    logic [15:0]           con;
    logic [9:0]            own;
    logic [7:0]            tx;
    logic [7:0]            rx;
    logic [BRG_W-1:0]      brg;
    logic [EV_N-1:0]       iflg;
    logic [EV_N-1:0]       ien;
    logic                  ackstat;
    logic                  tbf;
    logic                  rbf;
    logic                  addressed;
    logic                  rw_flag;
    logic [1:0]            scl_s;
    logic [1:0]            sda_s;
    logic                  scl_p;
    logic                  sda_p;
    i2cp_mst_t             ms;
    logic [1:0]            ph;
    logic [BRG_W-1:0]      div;
    logic [3:0]            mcnt;
    logic [7:0]            msh;
    logic                  mbus;
    logic                  m_scl;
    logic                  m_sda;
    i2cp_slv_t             ss;
    logic [3:0]            scnt;
    logic [7:0]            ssh;
    logic                  m10;
    logic                  s_sda;
    logic                  ack;
    logic [31:0]           dat;
    logic                  irq;
    logic                  owned;
    logic                  pin_lo;
    logic                  scl_oe_n;
    logic                  sda_oe_n;
  } i2cp_st_t;

  localparam i2cp_st_t ST_RST = '{
    con: CON_RST, brg: BRG_INIT, ms: M_IDLE, ss: S_IDLE,
    m_scl: 1'b1, m_sda: 1'b1, s_sda: 1'b1,
    scl_s: 2'h3, sda_s: 2'h3, scl_p: 1'b1, sda_p: 1'b1,
    scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

  i2cp_st_t        q;
  i2cp_st_t        d;
  logic            req;
  logic            scl;
  logic            sda;
  logic            tick;
  logic            last;
  logic            done;
  logic            bcl;
  logic            hit;
  logic            rise;
  logic            fall;
  logic            start_det;
  logic            stop_det;
  logic            slv_on;
  logic            slv_hold;
  logic [15:0]     wm;
  logic [15:0]     wv;
  logic [31:0]     rd;
  logic [EV_N-1:0] ev;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d         = q;
    ev        = '0;
    done      = 1'b0;
    bcl       = 1'b0;
    hit       = 1'b0;
    last      = 1'b0;
    rd        = '0;
    wv        = q.con;
    // Pins are asynchronous to the clock; only the second stage is used
    d.scl_s   = {q.scl_s[0], scl_i};
    d.sda_s   = {q.sda_s[0], sda_i};
    d.scl_p   = q.scl_s[1];
    d.sda_p   = q.sda_s[1];
    scl       = q.scl_s[1];
    sda       = q.sda_s[1];
    rise      = scl & ~q.scl_p;
    fall      = ~scl & q.scl_p;
    start_det = q.scl_p & scl & q.sda_p & ~sda;
    stop_det  = q.scl_p & scl & ~q.sda_p & sda;
    wm        = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    //////////////////////////////////////////////////////////////////////////
    // Register bus: one wait state, every address answers
    req   = wb_cyc_i & wb_stb_i & ~q.ack;
    d.ack = req;
    case (wb_adr_i)
      A_CON:   rd = {16'h0000, q.con};  // RULE1
      A_OWN:   rd = {22'h0, q.own};
      A_TX:    rd = {24'h000000, q.tx};
      A_RX:    rd = {24'h000000, q.rx};
      A_STAT:  rd = {24'h000000, q.mbus, q.ackstat, q.ms != M_IDLE, q.addressed,
                     q.rw_flag, q.rbf, q.tbf, q.ss != S_IDLE};
      A_IFLG:  rd = {{(32-EV_N){1'b0}}, q.iflg};
      A_IEN:   rd = {{(32-EV_N){1'b0}}, q.ien};
      A_BRG:   rd = {{(32-BRG_W){1'b0}}, q.brg};
      default: rd = '0;
    endcase
    if (req) begin
      d.dat = rd;
    end
    if (req && !wb_we_i && wb_adr_i == A_RX) begin
      d.rbf = 1'b0;
    end
    if (req && wb_we_i) begin
      case (wb_adr_i)
        A_CON: begin
          wv = (q.con & ~(wm & CON_WMASK)) | (wb_dat_i[15:0] & wm & CON_WMASK);
          if (!q.con[B_STRETCH_ENABLE] && !wv[B_REL]) begin
            wv[B_REL] = q.con[B_REL];  // RULE12
          end
          d.con = wv;
        end
        A_OWN:  d.own = (q.own & ~wm[9:0]) | (wb_dat_i[9:0] & wm[9:0]);
        A_TX: begin
          if (wb_sel_i[0]) begin
            d.tx  = wb_dat_i[7:0];
            d.tbf = 1'b1;
          end
        end
        A_ICLR: begin
          if (wb_sel_i[0]) begin
            d.iflg = q.iflg & ~wb_dat_i[EV_N-1:0];
          end
        end
        A_IEN: begin
          if (wb_sel_i[0]) begin
            d.ien = wb_dat_i[EV_N-1:0];
          end
        end
        A_BRG:  d.brg = (q.brg & ~wm[BRG_W-1:0]) | (wb_dat_i[BRG_W-1:0] & wm[BRG_W-1:0]);
        default: ;
      endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Master engine: four phases per bit, phase length set by brg
    // A released clock still read low is a stretching slave; wait for it
    tick = (q.div == '0) && !(q.m_scl && !scl);
    case (q.ms)
      M_IDLE: begin
        if (q.con[B_EN]) begin
          d.div  = q.brg;
          d.ph   = 2'h0;
          d.mcnt = '0;
          if (q.con[B_SEN] || q.con[B_RESTART_REQUEST]) begin
            d.ms    = M_START;
            d.m_sda = 1'b1;
          end else if (q.con[B_PEN]) begin
            d.ms    = M_STOP;
            d.m_sda = 1'b0;
          end else if (q.con[B_RECEIVE_REQUEST]) begin
            d.ms    = M_RX;
            d.m_sda = 1'b1;
          end else if (q.con[B_ACK_SEND_REQUEST]) begin
            d.ms    = M_ACK;
            d.m_sda = q.con[B_ACK_VALUE];
          end else if (q.tbf && q.mbus) begin
            // Address bytes of both widths are plain bytes to this engine
            d.ms    = M_TX;  // RULE4
            d.m_sda = q.tx[7];
            d.msh   = {q.tx[6:0], 1'b1};
          end
        end
      end
      default: begin
        if (q.div != '0) begin
          d.div = q.div - BRG_W'(1);
        end else if (tick) begin
          d.div = q.brg;
          d.ph  = q.ph + 2'h1;
          case (q.ms)
            M_START: begin
              case (q.ph)
                2'h0: d.m_scl = 1'b1;
                2'h1: begin
                  if (!sda) begin
                    bcl = 1'b1;  // RULE7
                  end else begin
                    d.m_sda = 1'b0;
                  end
                end
                2'h2: d.m_scl = 1'b0;
                default: begin
                  done   = 1'b1;
                  d.mbus = 1'b1;
                end
              endcase
            end
            M_STOP: begin
              case (q.ph)
                2'h0: d.m_scl = 1'b1;
                2'h1: d.m_sda = 1'b1;
                2'h2: ;
                default: begin
                  done   = 1'b1;
                  d.mbus = 1'b0;
                end
              endcase
            end
            default: begin
              case (q.ph)
                2'h0: begin
                  // Data moves a phase after the clock fell, so no slave sees a false start or stop
                  if (q.ms == M_TX && q.mcnt != '0) begin
                    d.m_sda = q.msh[7];
                    d.msh   = {q.msh[6:0], 1'b1};
                  end
                end
                2'h1: d.m_scl = 1'b1;
                2'h2: begin
                  if (q.ms == M_TX) begin
                    if (q.mcnt < BITS_BYTE) begin
                      if (q.m_sda && !sda) begin
                        bcl = 1'b1;  // RULE7
                      end
                    end else begin
                      d.ackstat = sda;
                    end
                  end else if (q.ms == M_RX) begin
                    d.msh = {q.msh[6:0], sda};
                  end
                end
                2'h3: begin
                  d.m_scl = 1'b0;
                  d.mcnt  = q.mcnt + 4'h1;
                  case (q.ms)
                    M_TX:    last = q.mcnt == BITS_BYTE;
                    M_RX:    last = q.mcnt == BITS_BYTE - 4'h1;
                    default: last = 1'b1;
                  endcase
                  if (last) begin
                    done = 1'b1;
                    if (q.ms == M_TX) begin
                      d.tbf = 1'b0;
                    end
                    if (q.ms == M_RX) begin
                      d.rx  = q.msh;
                      d.rbf = 1'b1;
                    end
                    // A sent ack level stays until the next operation moves it with the clock low
                  end
                end
                default: ;
              endcase
            end
          endcase
        end
      end
    endcase
    if (done) begin
      d.ms = M_IDLE;
      ev[EV_MST] = 1'b1;
      case (q.ms)  // RULE9
        M_START: begin
          d.con[B_SEN]  = 1'b0;
          d.con[B_RESTART_REQUEST] = 1'b0;
        end
        M_STOP:  d.con[B_PEN]   = 1'b0;
        M_RX:    d.con[B_RECEIVE_REQUEST]  = 1'b0;
        M_ACK:   d.con[B_ACK_SEND_REQUEST] = 1'b0;
        default: ;
      endcase
    end
    if (bcl) begin
      // Lost arbitration: let go of both lines and drop every request
      d.ms    = M_IDLE;  // RULE7
      d.m_scl = 1'b1;
      d.m_sda = 1'b1;
      d.mbus  = 1'b0;
      d.con   = d.con & ~CON_REQS;
      ev[EV_BCL] = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // Slave engine, idle while this port owns the bus as master
    slv_on = q.con[B_EN] && !q.mbus && q.ms == M_IDLE;
    if (!slv_on) begin
      d.ss = S_IDLE;
    end else if (start_det) begin
      d.ss    = S_ADDR;
      d.scnt  = '0;
      d.s_sda = 1'b1;
    end else if (stop_det) begin
      d.ss        = S_IDLE;
      d.m10       = 1'b0;
      d.addressed = 1'b0;
      d.s_sda     = 1'b1;
    end else if (q.ss != S_IDLE) begin
      if (rise) begin
        d.scnt = q.scnt + 4'h1;
        if (q.scnt < BITS_BYTE) begin
          d.ssh = {q.ssh[6:0], sda};
        end else if (q.ss == S_TX && sda) begin
          d.ss        = S_IDLE;
          d.addressed = 1'b0;
        end
      end
      if (fall) begin
        if (q.scnt == BITS_BYTE) begin
          case (q.ss)
            S_ADDR: begin
              if (q.con[B_A10]) begin  // RULE8
                hit = q.ssh[7:3] == HDR10 && q.ssh[2:1] == q.own[9:8]
                      && (!q.ssh[0] || q.m10);
              end else begin
                hit = q.ssh[7:1] == q.own[6:0]
                      || (q.con[B_GENERAL_CALL_ENABLE] && q.ssh == GCALL);
              end
              hit = hit || q.con[B_IPMI];  // RULE3
              if (hit) begin
                d.s_sda     = 1'b0;
                d.addressed = 1'b1;
                d.rw_flag   = q.ssh[0];
                ev[EV_SLV]  = 1'b1;
                if (q.ssh[0]) begin
                  d.ss = S_TX;
                  d.con[B_REL] = 1'b0;  // RULE10
                end else if (q.con[B_A10] && !q.con[B_IPMI]) begin
                  d.ss = S_ADDR2;
                end else begin
                  d.ss = S_RX;
                end
              end else begin
                d.ss = S_IDLE;
              end
            end
            S_ADDR2: begin
              if (q.ssh == q.own[7:0]) begin  // RULE3
                d.s_sda    = 1'b0;
                d.m10      = 1'b1;
                d.ss       = S_RX;
                ev[EV_SLV] = 1'b1;
              end else begin
                d.ss = S_IDLE;
              end
            end
            S_RX: begin
              // An unread byte is kept and the new one refused with a nack
              if (!q.rbf) begin
                d.rx = q.ssh;
              end
              d.s_sda    = q.rbf;
              d.rbf      = 1'b1;
              ev[EV_SLV] = 1'b1;
              if (q.con[B_STRETCH_ENABLE]) begin
                d.con[B_REL] = 1'b0;  // RULE6
              end
            end
            default: d.s_sda = 1'b1;
          endcase
        end else if (q.scnt == BITS_ACK) begin
          d.scnt  = '0;
          d.s_sda = 1'b1;
          if (q.ss == S_TX) begin
            d.con[B_REL] = 1'b0;  // RULE10
            ev[EV_SLV]   = 1'b1;
          end
        end else if (q.ss == S_TX) begin
          d.s_sda = q.ssh[7];
        end
      end
      // While stretched before a byte, present the latest transmit data
      if (q.ss == S_TX && q.scnt == '0 && !q.con[B_REL]) begin
        d.ssh   = q.tx;
        d.s_sda = q.tx[7];
        d.tbf   = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    if (!q.con[B_EN]) begin
      d.ms    = M_IDLE;  // RULE11
      d.ss    = S_IDLE;
      d.m_scl = 1'b1;
      d.m_sda = 1'b1;
      d.s_sda = 1'b1;
      d.mbus  = 1'b0;
    end
    // Hold only after the ack clock, so the master can finish the ack bit
    slv_hold   = d.ss != S_IDLE && !d.con[B_REL] && d.scnt == '0;  // RULE6
    d.scl_oe_n = !(d.con[B_EN] && (!d.m_scl || slv_hold));  // RULE2
    d.sda_oe_n = !(d.con[B_EN] && !(d.m_sda && d.s_sda));  // RULE2
    d.owned    = d.con[B_EN];  // RULE11
    d.iflg     = d.iflg | ev;
    d.irq      = |(d.iflg & d.ien);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      q <= ST_RST;  // RULE9
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o   = q.dat;
  assign wb_ack_o   = q.ack;
  assign scl_o      = q.pin_lo;
  assign sda_o      = q.pin_lo;
  assign scl_oe_n   = q.scl_oe_n;
  assign sda_oe_n   = q.sda_oe_n;
  assign pins_owned = q.owned;
  assign irq        = q.irq;

  // Standard and Fast speeds differ only in the phase length in brg
  // RULE5
endmodule // i2cp_port

/* File: verif/i2cp_port_asserts.sv */
`timescale 1ns/10ps
module i2cp_port_asserts (
  // Clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Serial pins
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe_n,
  input wire logic        sda_o,
  input wire logic        sda_oe_n,
  // Ownership and interrupt
  input wire logic        pins_owned,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_off;
    !pins_owned ##1 !pins_owned;
  endsequence
  // Start: data pulled while the clock line is released and high
  sequence s_start;
    $fell(sda_oe_n) && scl_oe_n && scl_i;
  endsequence
  sequence s_wr_past;
    $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_hi_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data above 16 bits not zero");
  a_drv_zero: assert property (!scl_o && !sda_o)
    else $error("open drain pin driven high");
  a_rst_quiet: assert property ($rose(nrst) |-> scl_oe_n && sda_oe_n && !pins_owned && !irq)
    else $error("outputs active after reset");
  a_idle_pins: assert property (s_off |-> scl_oe_n && sda_oe_n)
    else $error("pins driven while port disabled");
  a_own_drive: assert property (!scl_oe_n |-> pins_owned || $past(pins_owned))
    else $error("clock pulled without ownership");
  a_pins_follow: assert property ($changed(pins_owned) |-> s_wr_past)
    else $error("ownership changed without a write");
  // Sticky flags only drop through a software write
  a_irq_clear: assert property ($fell(irq) |-> s_wr_past or $past(wb_cyc_i && wb_we_i, 3))
    else $error("interrupt dropped without a write");
  a_start_scl: assert property (s_start |-> ##[1:1000] (!scl_oe_n || sda_oe_n))
    else $error("start not followed by clock low");
endmodule // i2cp_port_asserts

/* File: verif/i2cp_target.sv */
`timescale 1ns/10ps
module i2cp_target #(
  parameter logic [6:0] ADDR = 7'h52
) (
  // Line levels
  input  wire logic       scl,
  input  wire logic       sda,
  // Misbehaviour controls
  input  wire logic       collide,
  input  wire logic       slow,
  // Pulls, low means pull the line, and the last byte seen on the bus
  output logic            sda_n,
  output logic            scl_n,
  output logic [7:0]      rx_byte
);
  int         bitn;
  logic [7:0] sh;
  logic       sel;
  logic       first;
  logic       ack_n;
  initial begin
    ack_n   = 1'b1;
    scl_n   = 1'b1;
    bitn    = -1;
    sel     = 1'b0;
    first   = 1'b0;
    rx_byte = 8'h00;
  end
  // Colliding holds data low regardless of the bus state
  assign sda_n = ack_n & !collide;
  always @(negedge sda) if (scl) begin
    bitn  = -1;
    first = 1'b1;
  end
  always @(posedge sda) if (scl) begin
    sel   = 1'b0;
    first = 1'b0;
  end
  always @(posedge scl) if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
  always @(negedge scl) begin
    bitn++;
    if (bitn == 8) begin
      rx_byte = sh;
      if (first) sel = (sh[7:1] == ADDR);
      first = 1'b0;
      ack_n = !sel;
    end else if (bitn == 9) begin
      ack_n = 1'b1;
      bitn  = 0;
      // Stretch after each byte to force the master to wait
      if (slow) begin
        scl_n = 1'b0;
        #300;
        scl_n = 1'b1;
      end
    end
  end
endmodule // i2cp_target

/* File: verif/test_i2cp_port.sv */
`timescale 1ns/10ps
module test_i2cp_port;
  import i2cp_pkg::*;
  logic        clock, nrst, cyc, stb, we, collide, slow;
  logic [7:0]  adr, got;
  logic [31:0] dat, q, rd;
  logic        ack, scl_o, scl_oe_n, sda_o, sda_oe_n, owned, irq;
  logic        t_scl_n, t_sda_n, scl, sda, m_scl_n, m_sda_n, lvl;
  int          err_total, compares;
  assign scl = scl_oe_n & t_scl_n & m_scl_n;
  assign sda = sda_oe_n & t_sda_n & m_sda_n;
  always #4 clock = ~clock;
  i2cp_port #(.BRG_INIT(10'h004)) u_dut (.clock(clock), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .pins_owned(owned), .irq(irq));
  i2cp_target u_tgt (.scl(scl), .sda(sda), .collide(collide), .slow(slow),
    .sda_n(t_sda_n), .scl_n(t_scl_n), .rx_byte(got));
  ////////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    n = 0;
    do begin @(posedge clock); n++; end while (ack !== 1'b1 && n < 50);
    q = rd;
    cyc <= 1'b0; stb <= 1'b0;
    if (ack !== 1'b1) begin err_total++; give_verdict; end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask
  // Reads until the masked field is set or clear, bounded
  task poll(input logic [7:0] a, input logic [31:0] m, input logic set);
    int n;
    n = 0;
    do begin xfer(a, 1'b0, 32'h0); n++; end while (((q & m) != 0) !== set && n < 400);
    if (((q & m) != 0) !== set) begin err_total++; give_verdict; end
  endtask
  task send(input logic [7:0] b);
    xfer(A_TX, 1'b1, {24'h0, b});
    poll(A_IFLG, 32'h1, 1'b1);
    xfer(A_ICLR, 1'b1, 32'h1);
    xfer(A_STAT, 1'b0, 32'h0);
  endtask
  task bus_op(input logic [31:0] c, input logic [31:0] m);
    xfer(A_CON, 1'b1, c);
    poll(A_CON, m, 1'b0);
    xfer(A_ICLR, 1'b1, 32'h1);
  endtask
  // Bench as link master: one bit in ten clocks, 80 ns; lvl is the data line while high
  task lbit(input logic b);
    m_sda_n <= b;
    repeat (3) @(posedge clock);
    m_scl_n <= 1'b1;
    repeat (4) @(posedge clock);
    lvl = sda;
    @(posedge clock);
    m_scl_n <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task lbyte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) lbit(b[i]);
    lbit(1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 0; nrst = 0; cyc = 0; stb = 0; we = 0; adr = 0; dat = 0;
    collide = 0; slow = 0; err_total = 0; compares = 0; m_scl_n = 1; m_sda_n = 1;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rdc("control reset", A_CON, {16'h0, CON_RST});
    rdc("unmapped", 8'h30, 32'h0);
    xfer(A_IFLG, 1'b1, 32'hFFFF);
    rdc("flags read only", A_IFLG, 32'h0);
    chk("owned off", 32'h0, {31'h0, owned});
    xfer(A_CON, 1'b1, 32'hC000);
    rdc("enable", A_CON, 32'h9000);
    chk("owned on", 32'h1, {31'h0, owned});
    xfer(A_CON, 1'b1, 32'h8000);
    rdc("release kept", A_CON, 32'h9000);
    xfer(A_CON, 1'b1, 32'h8040);
    rdc("stretch set first", A_CON, 32'h9040);
    xfer(A_CON, 1'b1, 32'h8040);
    rdc("release held", A_CON, 32'h8040);
    xfer(A_CON, 1'b1, 32'h9000);
    xfer(A_IEN, 1'b1, 32'h1);
    slow <= 1'b1;
    xfer(A_CON, 1'b1, 32'h9001);
    poll(A_CON, 32'h1, 1'b0);
    rdc("start flag", A_IFLG, 32'h1);
    chk("irq raised", 32'h1, {31'h0, irq});
    xfer(A_ICLR, 1'b1, 32'h1);
    rdc("flag cleared", A_IFLG, 32'h0);
    chk("irq dropped", 32'h0, {31'h0, irq});
    send(8'hA4);
    chk("address acked", 32'h0, {31'h0, q[6]});
    chk("address byte", 32'hA4, {24'h0, got});
    xfer(A_IEN, 1'b1, 32'h0);
    send(8'h5A);
    chk("irq masked", 32'h0, {31'h0, irq});
    chk("data byte", 32'h5A, {24'h0, got});
    bus_op(32'h9004, 32'h4);
    chk("lines idle", 32'h3, {30'h0, scl, sda});
    bus_op(32'h9001, 32'h1);
    send(8'h40);
    chk("wrong address nack", 32'h1, {31'h0, q[6]});
    bus_op(32'h9004, 32'h4);
    collide <= 1'b1;
    xfer(A_IEN, 1'b1, 32'h4);
    xfer(A_CON, 1'b1, 32'h9001);
    poll(A_IFLG, 32'h4, 1'b1);
    chk("irq collision", 32'h1, {31'h0, irq});
    collide <= 1'b0;
    xfer(A_ICLR, 1'b1, 32'h7);
    slow <= 1'b0;
    xfer(A_OWN, 1'b1, 32'h33);
    xfer(A_CON, 1'b1, 32'h9040);
    m_sda_n <= 1'b0;
    repeat (4) @(posedge clock);
    m_scl_n <= 1'b0;
    repeat (2) @(posedge clock);
    lbyte(8'h66);
    chk("slave address ack", 32'h0, {31'h0, lvl});
    lbyte(8'hC3);
    chk("slave data ack", 32'h0, {31'h0, lvl});
    repeat (4) @(posedge clock);
    m_scl_n <= 1'b1;
    repeat (8) @(posedge clock);
    chk("slave stretch", 32'h0, {31'h0, scl});
    rdc("release cleared", A_CON, 32'h8040);
    rdc("slave byte", A_RX, 32'hC3);
    rdc("slave flag", A_IFLG, 32'h2);
    xfer(A_CON, 1'b1, 32'h9040);
    repeat (4) @(posedge clock);
    chk("slave released", 32'h1, {31'h0, scl});
    xfer(A_CON, 1'b1, 32'h1000);
    repeat (3) @(posedge clock);
    chk("owned released", 32'h0, {31'h0, owned});
    chk("pins released", 32'h3, {30'h0, scl_oe_n, sda_oe_n});
    give_verdict;
  end
endmodule // test_i2cp_port
bind i2cp_port i2cp_port_asserts u_chk (.clock(clock), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
  .pins_owned(pins_owned), .irq(irq));
